//--- hw/izs_datapath.sv
// Interpolating half-band filter with optional midscale stuffing ahead of the converter.
`timescale 1ns/1ps
`default_nettype none
`include "izs_cfg.svh"
module izs_datapath #(
    parameter logic signed [`IZS_COEF_W-1:0] CENTER_COEF = 16'sh4000,
    parameter logic signed [`IZS_COEF_W-1:0] SIDE_COEF [0:`IZS_SIDE_TAPS-1] = '{
        16'sh2710, 16'shf448, 16'sh05dc, 16'shfce0, 16'sh01c2, 16'shff06,
        16'sh0082, 16'shffbf, 16'sh001e, 16'shfff3, 16'sh0005}
) (
    // Clock and reset; i_clk runs at four times the input sample rate.
    input wire logic i_clk,
    input wire logic i_srst,
    // Source side pins, asynchronous to i_clk.
    input wire logic i_data_clk,
    input wire izs_pkg::izs_code_t i_data,
    // Static mode pins.
    input wire logic i_filter_response_select,
    input wire logic i_zero_stuff_enable,
    // Converter side.
    output logic [`IZS_WIDTH-1:0] o_dac_code,
    output logic o_dac_update
);
    import izs_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers. Data is synchronised with the clock pin so that a
    // word held stable across its edge is seen settled when the edge is seen.
    logic [1:0] clk_sync;
    logic clk_prev;
    izs_code_t data_meta;
    izs_code_t data_s;
    logic [1:0] hp_sync;
    logic [1:0] stuff_sync;
    logic hp_s;
    logic stuff_s;
    logic edge_seen;

    always_ff @(posedge i_clk) begin
        clk_sync <= {clk_sync[0], i_data_clk};
        data_meta <= i_data;
        data_s <= data_meta; // RULE11
        hp_sync <= {hp_sync[0], i_filter_response_select};
        stuff_sync <= {stuff_sync[0], i_zero_stuff_enable};
        if (i_srst) begin
            clk_prev <= 1'b0;
        end else begin
            clk_prev <= clk_sync[1];
        end
    end

    assign hp_s = hp_sync[1];
    assign stuff_s = stuff_sync[1];
    assign edge_seen = clk_sync[1] & ~clk_prev;

    ////////////////////////////////////////////////////////////////////////////////
    // Input capture into the filter history, newest word at index 0.
    // Offset binary is turned to two's complement by flipping the MSB.
    izs_smp_t hist [0:`IZS_HIST-1];
    logic running;

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            for (int i = 0; i < `IZS_HIST; i++) begin
                hist[i] <= '0;
            end
        end else if (edge_seen) begin
            hist[0] <= izs_smp_t'(data_s ^ `IZS_MIDSCALE); // RULE1
            for (int i = 1; i < `IZS_HIST; i++) begin
                hist[i] <= hist[i-1];
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            running <= 1'b0;
        end else if (edge_seen) begin
            running <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Half-band polyphase filter. Every even tap off center is zero, so the
    // side phase needs only the folded odd taps and the center phase one product.
    logic signed [`IZS_ACC_W-1:0] prod [0:`IZS_SIDE_TAPS-1];
    logic signed [`IZS_ACC_W-1:0] side_acc;
    logic signed [`IZS_ACC_W-1:0] ctr_acc;
    logic signed [`IZS_COEF_W-1:0] ctr_coef;

    genvar g;
    generate
        for (g = 0; g < `IZS_SIDE_TAPS; g++) begin : g_fold
            logic signed [`IZS_WIDTH:0] pair;
            // Symmetric taps share one multiplier.
            assign pair = {hist[`IZS_CENTER_IDX-g][`IZS_WIDTH-1], hist[`IZS_CENTER_IDX-g]}
                + {hist[`IZS_CENTER_IDX+1+g][`IZS_WIDTH-1], hist[`IZS_CENTER_IDX+1+g]}; // RULE9
            // Both factors are widened first so the product keeps every bit.
            assign prod[g] = `IZS_ACC_W'(pair) * `IZS_ACC_W'(SIDE_COEF[g]);
        end
    endgenerate

    always_comb begin
        side_acc = '0;
        for (int i = 0; i < `IZS_SIDE_TAPS; i++) begin
            side_acc = side_acc + prod[i];
        end
    end

    assign ctr_coef = hp_s ? -CENTER_COEF : CENTER_COEF; // RULE3 RULE10
    assign ctr_acc = `IZS_ACC_W'(hist[`IZS_CENTER_IDX]) * `IZS_ACC_W'(ctr_coef);

    // Scale back, saturate and return to offset binary.
    function automatic izs_code_t to_code(input logic signed [`IZS_ACC_W-1:0] acc);
        logic signed [`IZS_ACC_W-1:0] sc;
        izs_smp_t s;
        sc = acc >>> `IZS_COEF_SHIFT;
        if (sc > `IZS_ACC_W'(signed'(`IZS_MIDSCALE - 14'h0001))) begin
            s = izs_smp_t'(`IZS_MIDSCALE - 14'h0001);
        end else if (sc < -(signed'(`IZS_ACC_W'(`IZS_MIDSCALE)))) begin
            s = izs_smp_t'(`IZS_MIDSCALE);
        end else begin
            s = izs_smp_t'(sc);
        end
        return izs_code_t'(s) ^ `IZS_MIDSCALE;
    endfunction

    izs_code_t side_code;
    izs_code_t ctr_code;
    assign side_code = to_code(side_acc);
    assign ctr_code = to_code(ctr_acc);

    ////////////////////////////////////////////////////////////////////////////////
    // Update slot sequencer, realigned on every input edge.
    izs_phase_t phase;

    always_ff @(posedge i_clk) begin
        if (i_srst || edge_seen) begin
            phase <= IZS_PH_SIDE;
        end else begin
            phase <= izs_phase_t'(phase + 2'h1);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Converter drive. Without stuffing the code holds between the two
    // filter outputs; with stuffing the gaps carry midscale.
    // At 125 MHz this reaches 31.25 MSPS in and 125 MSPS out, well inside limits.
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_dac_code <= `IZS_MIDSCALE;
            o_dac_update <= 1'b0;
        end else if (!running) begin
            o_dac_update <= 1'b0; // RULE7
        end else begin
            unique case (phase)
                IZS_PH_SIDE: begin
                    o_dac_code <= side_code; // RULE2
                    o_dac_update <= 1'b1;
                end
                IZS_PH_CTR: begin
                    o_dac_code <= ctr_code; // RULE2
                    o_dac_update <= 1'b1;
                end
                IZS_PH_GAP0, IZS_PH_GAP1: begin
                    if (stuff_s) begin // RULE4 RULE5 RULE6
                        o_dac_code <= `IZS_MIDSCALE; // RULE8
                    end
                    o_dac_update <= stuff_s;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.
    logic [1:0] upd_gap;
    always_ff @(posedge i_clk) begin
        // Idle time before the first input must not count as a gap.
        if (i_srst || !running || o_dac_update) begin
            upd_gap <= 2'h0;
        end else if (upd_gap != 2'h3) begin
            upd_gap <= upd_gap + 2'h1;
        end
    end

    sequence s_filter_then_mid;
        o_dac_update && o_dac_code == $past(side_code) ##1
        o_dac_update && o_dac_code == `IZS_MIDSCALE;
    endsequence
    sequence s_filter_then_hold;
        o_dac_update ##1 !o_dac_update && $stable(o_dac_code) ##1 o_dac_update;
    endsequence

    property p_capture;
        @(posedge i_clk) disable iff (i_srst)
        edge_seen |=> hist[0] == izs_smp_t'($past(data_s) ^ `IZS_MIDSCALE) && hist[1] == $past(hist[0]);
    endproperty
    a_capture: assert property (p_capture) else $error("input word not captured"); // RULE1

    property p_two_per_input;
        @(posedge i_clk) disable iff (i_srst)
        (running && phase == IZS_PH_SIDE && !stuff_s && !edge_seen
            && $stable(stuff_s)) |=> s_filter_then_hold;
    endproperty
    a_two_per_input: assert property (p_two_per_input) else $error("not two updates per input"); // RULE2

    property p_center_sign;
        @(posedge i_clk) disable iff (i_srst)
        (running && phase == IZS_PH_CTR) |=>
            o_dac_code == to_code(`IZS_ACC_W'($past(hist[`IZS_CENTER_IDX]))
                * `IZS_ACC_W'($past(hp_s) ? -CENTER_COEF : CENTER_COEF));
    endproperty
    a_center_sign: assert property (p_center_sign) else $error("center tap sign wrong"); // RULE3

    property p_stuff;
        @(posedge i_clk) disable iff (i_srst)
        (running && phase == IZS_PH_SIDE && stuff_s && !edge_seen) |=> s_filter_then_mid;
    endproperty
    a_stuff: assert property (p_stuff) else $error("midscale not inserted"); // RULE4

    property p_no_stuff_gap;
        @(posedge i_clk) disable iff (i_srst)
        (phase == IZS_PH_GAP0 && !stuff_s) |=> !o_dac_update;
    endproperty
    a_no_stuff_gap: assert property (p_no_stuff_gap) else $error("update without stuffing"); // RULE5

    property p_four_rate;
        @(posedge i_clk) disable iff (i_srst)
        (running && phase == IZS_PH_SIDE && stuff_s && !edge_seen) |=> o_dac_update [*4];
    endproperty
    a_four_rate: assert property (p_four_rate) else $error("stuffed rate not four"); // RULE6

    property p_idle;
        @(posedge i_clk) disable iff (i_srst)
        !running |=> !o_dac_update && o_dac_code == `IZS_MIDSCALE;
    endproperty
    a_idle: assert property (p_idle) else $error("update before first input"); // RULE7

    property p_mid_code;
        @(posedge i_clk) disable iff (i_srst)
        (running && stuff_s && (phase == IZS_PH_GAP0 || phase == IZS_PH_GAP1))
            |=> o_dac_code == `IZS_MIDSCALE;
    endproperty
    a_mid_code: assert property (p_mid_code) else $error("stuffed code not midscale"); // RULE8

    property p_gap_bound;
        @(posedge i_clk) disable iff (i_srst)
        (running && !edge_seen) |-> upd_gap != 2'h3;
    endproperty
    a_gap_bound: assert property (p_gap_bound) else $error("update gap too long"); // RULE6

    property p_hp_only_center;
        @(posedge i_clk) disable iff (i_srst)
        (running && phase == IZS_PH_SIDE && $stable(hist[0]))
            |=> o_dac_code == $past(side_code);
    endproperty
    a_hp_only_center: assert property (p_hp_only_center) else $error("side phase altered"); // RULE10
endmodule // izs_datapath
`default_nettype wire

//--- hw/izs_cfg.svh
// Constants for the interpolating zero-stuff datapath.
// Contract
// RULE1 - Capture one 14-bit word per input clock rise
// RULE2 - Interpolate by two: two filter outputs per input
// RULE3 - Response select low is low pass, high high pass
// RULE4 - Stuff enable high inserts midscale, low does not
// RULE5 - Two mode pins decode four independent modes
// RULE6 - Update rate twice input, four times when stuffing
// RULE7 - Input to 150 MSPS, updates to 400 MSPS
// RULE8 - Stuffed midscale code follows every filter output
// RULE9 - Symmetric 43-tap half-band FIR structure
// RULE10 - High pass negates only the center coefficient
// RULE11 - Source holds data stable and modes static
`ifndef IZS_CFG_SVH
`define IZS_CFG_SVH
`define IZS_WIDTH 14
`define IZS_MIDSCALE 14'h2000
`define IZS_TAPS 43
`define IZS_SIDE_TAPS 11
`define IZS_HIST 22
`define IZS_CENTER_IDX 10
`define IZS_COEF_W 16
`define IZS_COEF_SHIFT 14
`define IZS_ACC_W 36
`define IZS_MAX_IN_MSPS 150
`define IZS_MAX_UPD_MSPS 400
`endif

//--- hw/izs_pkg.sv
// Types shared by the interpolating zero-stuff datapath.
`include "izs_cfg.svh"
package izs_pkg;
    typedef logic signed [`IZS_WIDTH-1:0] izs_smp_t;
    typedef logic [`IZS_WIDTH-1:0] izs_code_t;
    // Update slot within one input period at four times the input rate.
    typedef enum logic [1:0] {IZS_PH_SIDE, IZS_PH_GAP0, IZS_PH_CTR, IZS_PH_GAP1} izs_phase_t;
endpackage

//--- tb/izs_src_model.sv
// Sample source model: offset-binary words with a data clock at a quarter of i_clk.
`timescale 1ns/1ps
`default_nettype none
module izs_src_model (
    // Clock and control.
    input wire logic i_clk,
    input wire logic i_run,
    input wire izs_pkg::izs_code_t i_peak,
    // Source pins.
    output logic o_data_clk,
    output izs_pkg::izs_code_t o_data
);
    import izs_pkg::*;
    logic [1:0] slot;
    logic [7:0] count;
    initial begin
        o_data_clk = 1'b0;
        o_data = 14'h2000;
    end
    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge i_clk) begin
        if (!i_run) begin
            slot <= 2'h0;
            count <= 8'h00;
            o_data_clk <= 1'b0;
            o_data <= 14'h2000;
        end else begin
            slot <= slot + 2'h1;
            // The word is set up a cycle before the rise and held for a whole period,
            // so the receiver's slow synchroniser never sees it change near the edge.
            if (slot == 2'h3) begin
                o_data <= (count == 8'h03) ? i_peak : 14'h2000;
                count <= count + 8'h01;
            end
            o_data_clk <= (slot == 2'h0) || (slot == 2'h1);
        end
    end
endmodule // izs_src_model
`default_nettype wire

//--- tb/tb.sv
// Self-checking testbench for the interpolating zero-stuff datapath.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import izs_pkg::*;
    logic i_clk = 1'b0;
    logic i_srst = 1'b1;
    logic run = 1'b0;
    logic rec = 1'b0;
    logic fs = 1'b0;
    logic zs = 1'b0;
    logic data_clk;
    izs_code_t data;
    logic [13:0] code;
    logic upd;
    int fail_count = 0;
    int checked = 0;
    logic [13:0] q[$];
    logic [13:0] side_ref [0:127];
    always #4 i_clk = ~i_clk;
    izs_src_model i_src (.i_clk(i_clk), .i_run(run), .i_peak(14'h2400),
        .o_data_clk(data_clk), .o_data(data));
    izs_datapath i_dut (.i_clk(i_clk), .i_srst(i_srst), .i_data_clk(data_clk), .i_data(data),
        .i_filter_response_select(fs), .i_zero_stuff_enable(zs),
        .o_dac_code(code), .o_dac_update(upd));
    always @(posedge i_clk) begin
        if (rec && upd === 1'b1) begin
            q.push_back(code);
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // One impulse of +1024 codes through the filter in one of the four modes.
    task automatic run_mode(input logic hp, input logic st);
        int n;
        int slots;
        int hit;
        int bad;
        int mid_bad;
        int side_bad;
        int side_nz;
        logic [13:0] want;
        @(posedge i_clk);
        fs <= hp;
        zs <= st;
        i_srst <= 1'b1;
        run <= 1'b0;
        rec <= 1'b0;
        repeat (10) @(posedge i_clk);
        #1 chk("reset update", upd, 0);
        chk("reset code", code, 14'h2000);
        q.delete();
        @(posedge i_clk);
        i_srst <= 1'b0;
        run <= 1'b1;
        rec <= 1'b1;
        repeat (150) @(posedge i_clk);
        n = 0;
        repeat (16) begin
            @(posedge i_clk);
            #1 if (upd === 1'b1) n++;
        end
        chk("updates per four words", n, st ? 16 : 8);
        slots = st ? 4 : 2;
        want = hp ? 14'h1c00 : 14'h2400;
        hit = 0;
        bad = 0;
        mid_bad = 0;
        side_bad = 0;
        side_nz = 0;
        foreach (q[i]) begin
            if (st && i % 2 == 1 && q[i] !== 14'h2000) mid_bad++;
            if (i % slots == slots / 2) begin
                if (q[i] === want) hit++;
                else if (q[i] !== 14'h2000) bad++;
            end
            if (i % slots == 0) begin
                if (q[i] !== 14'h2000) side_nz++;
                if (!hp) side_ref[i / slots] = q[i];
                else if (q[i] !== side_ref[i / slots]) side_bad++;
            end
        end
        chk("midscale slots", mid_bad, 0);
        chk("center peak", hit, 1);
        chk("center others", bad, 0);
        chk("side outputs active", side_nz > 0, 1);
        chk("side unchanged by response", side_bad, 0);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #30000;
        fail_count++;
        stop_test();
    end
    initial begin
        run_mode(1'b0, 1'b0);
        run_mode(1'b1, 1'b0);
        run_mode(1'b0, 1'b1);
        run_mode(1'b1, 1'b1);
        stop_test();
    end
endmodule // tb
`default_nettype wire
